// ---- inc/pvsr_consts.svh ----
`ifndef PVSR_CONSTS_SVH
`define PVSR_CONSTS_SVH

// ==========================================
// Register offsets (5-bit management address)
`define PVSR_OFS_SYMERR  5'h1A
`define PVSR_OFS_XOVER   5'h1B
`define PVSR_OFS_TEST    5'h1C
`define PVSR_OFS_FLAGS   5'h1D
`define PVSR_OFS_MASK    5'h1E
`define PVSR_OFS_SPECIAL 5'h1F

// ==========================================
// Crossover/polarity register fields
`define PVSR_XO_AUTO_BIT   15
`define PVSR_XO_PAIR_BIT   13
`define PVSR_XO_HB_BIT     11
`define PVSR_XO_POL_BIT    4

// ==========================================
// Flag and mask register fields
`define PVSR_IRQ_LO        1
`define PVSR_IRQ_HI        7

// ==========================================
// Special control/status fields
`define PVSR_SP_DONE_BIT   12
`define PVSR_SP_GPO_LO     7
`define PVSR_SP_GPO_HI     9
`define PVSR_SP_ENC_BIT    6
`define PVSR_SP_SPD_LO     2
`define PVSR_SP_SPD_HI     4
`define PVSR_SP_SCR_BIT    0

// ==========================================
// Reset values
`define PVSR_RST_CNT       16'h0000
`define PVSR_RST_MASK      7'h00
`define PVSR_RST_GPO       3'h0
`define PVSR_RST_ENC       1'b1
`define PVSR_RST_SCR_DIS   1'b0
`define PVSR_RST_AUTO      1'b0
`define PVSR_RST_PAIR      1'b0
`define PVSR_RST_HB_DIS    1'b0

`endif

// ---- inc/pvsr_pkg.sv ----
package pvsr_pkg;

	// Per-packet symbol error tracking
	typedef enum logic [1:0] {
		PVSR_IDLE,
		PVSR_PKT_OPEN,
		PVSR_PKT_DONE
	} pvsr_pkt_state_t;

	// 16-bit management data word
	typedef logic [15:0] pvsr_word_t;

endpackage

// ---- src/pvsr_flag_cell.sv ----
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// One latched interrupt source flag
module pvsr_flag_cell #(
	parameter bit FALL_ASSERT   = 1'b0,
	parameter bit EDGE_DEASSERT = 1'b1
) (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic soft_reset_in,
	input  wire logic src_in,
	input  wire logic alt_mode_in,
	input  wire logic rd_clear_in,
	input  wire logic wr_one_in,
	output var  logic flag_out
);
	logic src_q;
	logic set_ev;
	logic clr_ev;
	logic deassert_lvl;

	// Remember the source to find its edges
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			src_q <= 1'b0;
		else
			src_q <= src_in;
	end

	// Assert edge, and the level that allows a clear
	always_comb begin
		set_ev       = FALL_ASSERT ? (src_q & ~src_in) : (~src_q & src_in);
		deassert_lvl = FALL_ASSERT ? src_in : ~src_in;
		if (alt_mode_in)
			clr_ev = wr_one_in & deassert_lvl;
		else
			clr_ev = rd_clear_in | (EDGE_DEASSERT & (FALL_ASSERT ? (~src_q & src_in) : (src_q & ~src_in)));
	end

	// Latch high; a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			flag_out <= 1'b0;
		else if (soft_reset_in)
			flag_out <= 1'b0;
		else
			flag_out <= set_ev | (flag_out & ~clr_ev);
	end

	flag_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		flag_out && !clr_ev && !soft_reset_in |=> flag_out)
		else $error("latched flag dropped without a clear");
	set_wins_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		set_ev && !soft_reset_in |=> flag_out)
		else $error("source event not latched");
	alt_keep_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		alt_mode_in && wr_one_in && flag_out && !deassert_lvl && !soft_reset_in |=> flag_out)
		else $error("flag cleared while source still active");
	rd_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!alt_mode_in && rd_clear_in && !set_ev |=> !flag_out)
		else $error("flag survived a read in primary mode");

endmodule // pvsr_flag_cell

`default_nettype wire

// ---- src/pvsr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "pvsr_consts.svh"

module pvsr_regs
	import pvsr_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       soft_reset_in,
	input  wire logic       mgmt_rd_in,
	input  wire logic       mgmt_wr_in,
	input  wire logic [4:0] mgmt_addr_in,
	input  wire logic [15:0] mgmt_wdata_in,
	output var  logic [15:0] mgmt_rdata_out,
	input  wire logic       speed_100_in,
	input  wire logic       rx_in_packet_in,
	input  wire logic       symbol_error_in,
	input  wire logic       auto_pair_swap_in,
	input  wire logic       rx_polarity_reversed_in,
	input  wire logic [2:0] resolved_speed_duplex_in,
	input  wire logic       alt_irq_mode_in,
	input  wire logic       line_energy_present_in,
	input  wire logic       neg_complete_in,
	input  wire logic       remote_fault_in,
	input  wire logic       link_up_in,
	input  wire logic       partner_ack_in,
	input  wire logic       parallel_fault_in,
	input  wire logic       page_received_in,
	output var  logic       pair_swap_out,
	output var  logic       auto_crossover_en_out,
	output var  logic       heartbeat_test_en_out,
	output var  logic [2:0] general_outputs_out,
	output var  logic       enc_4b5b_en_out,
	output var  logic       scramble_en_out,
	output var  logic       interrupt_out_n
);

	// ==========================================
	// Elaboration check
	generate
		if (CNT_W != 16) begin : g_bad_width
			$error("symbol error counter must be 16 bits wide");
		end
	endgenerate

	// ==========================================
	// Internal state
	logic [CNT_W-1:0] symbol_error_count;
	pvsr_pkt_state_t  pkt_state;
	pvsr_pkt_state_t  next_pkt_state;
	logic             cnt_inc;
	logic             crossover_auto_control;
	logic             manual_pair_select;
	logic             heartbeat_test_disable;
	logic             rx_polarity_reversed;
	logic [7:1]       irq_mask;
	logic [7:1]       irq_flags;
	logic [2:0]       general_outputs;
	logic             enc_4b5b_en;
	logic             scramble_disable;
	logic             negotiation_done;
	logic [2:0]       resolved_speed_duplex;
	logic             wr_xover;
	logic             wr_mask;
	logic             wr_special;
	logic             wr_flags;
	logic             rd_flags;
	pvsr_word_t       next_rdata;

	// ==========================================
	// Address decode for writes and side-effect reads
	always_comb begin
		wr_xover   = 1'b0;
		wr_mask    = 1'b0;
		wr_special = 1'b0;
		wr_flags   = 1'b0;
		rd_flags   = 1'b0;
		if (mgmt_wr_in && mgmt_addr_in == `PVSR_OFS_XOVER)
			wr_xover = 1'b1;
		else if (mgmt_wr_in && mgmt_addr_in == `PVSR_OFS_MASK)
			wr_mask = 1'b1;
		else if (mgmt_wr_in && mgmt_addr_in == `PVSR_OFS_SPECIAL)
			wr_special = 1'b1;
		else if (mgmt_wr_in && mgmt_addr_in == `PVSR_OFS_FLAGS)
			wr_flags = 1'b1;
		else if (mgmt_rd_in && mgmt_addr_in == `PVSR_OFS_FLAGS)
			rd_flags = 1'b1;
		// Writes to the test register are dropped: it has no storage here
	end

	// ==========================================
	// Packet tracker: at most one count per packet
	always_comb begin
		next_pkt_state = pkt_state;
		case (pkt_state)
			PVSR_IDLE: begin
				if (rx_in_packet_in)
					next_pkt_state = (symbol_error_in && speed_100_in) ? PVSR_PKT_DONE : PVSR_PKT_OPEN;
			end
			PVSR_PKT_OPEN: begin
				if (!rx_in_packet_in)
					next_pkt_state = PVSR_IDLE;
				else if (symbol_error_in && speed_100_in)
					next_pkt_state = PVSR_PKT_DONE;
			end
			PVSR_PKT_DONE: begin
				if (!rx_in_packet_in)
					next_pkt_state = PVSR_IDLE;
			end
			default: next_pkt_state = PVSR_IDLE;
		endcase
	end

	// At 100 Mb/s idle errors always count; packet errors only until the first
	assign cnt_inc = speed_100_in & symbol_error_in &
		((pkt_state != PVSR_PKT_DONE) | ~rx_in_packet_in);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			pkt_state <= PVSR_IDLE;
		else if (soft_reset_in)
			pkt_state <= PVSR_IDLE;
		else
			pkt_state <= next_pkt_state;
	end

	// Counter wraps by plain binary overflow; reads never touch it
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			symbol_error_count <= `PVSR_RST_CNT;
		else if (soft_reset_in)
			symbol_error_count <= `PVSR_RST_CNT;
		else if (cnt_inc)
			symbol_error_count <= symbol_error_count + CNT_W'(1);
	end

	// ==========================================
	// Crossover and heartbeat control
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			crossover_auto_control <= `PVSR_RST_AUTO;
			manual_pair_select     <= `PVSR_RST_PAIR;
			heartbeat_test_disable <= `PVSR_RST_HB_DIS;
		end else if (soft_reset_in) begin
			crossover_auto_control <= `PVSR_RST_AUTO;
			manual_pair_select     <= `PVSR_RST_PAIR;
			heartbeat_test_disable <= `PVSR_RST_HB_DIS;
		end else if (wr_xover) begin
			crossover_auto_control <= mgmt_wdata_in[`PVSR_XO_AUTO_BIT];
			manual_pair_select     <= mgmt_wdata_in[`PVSR_XO_PAIR_BIT];
			heartbeat_test_disable <= mgmt_wdata_in[`PVSR_XO_HB_BIT];
		end
	end

	// Pair choice: automatic result or the manual bit alone
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pair_swap_out         <= 1'b0;
			auto_crossover_en_out <= 1'b1;
			heartbeat_test_en_out <= 1'b1;
		end else begin
			pair_swap_out         <= crossover_auto_control ? manual_pair_select : auto_pair_swap_in;
			auto_crossover_en_out <= ~crossover_auto_control;
			heartbeat_test_en_out <= ~heartbeat_test_disable;
		end
	end

	// ==========================================
	// Status captured from the transceiver core
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_polarity_reversed  <= 1'b0;
			negotiation_done      <= 1'b0;
			resolved_speed_duplex <= 3'h0;
		end else begin
			rx_polarity_reversed  <= rx_polarity_reversed_in;
			negotiation_done      <= neg_complete_in;
			resolved_speed_duplex <= resolved_speed_duplex_in;
		end
	end

	// ==========================================
	// Special control: outputs, 4B5B and scrambler
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			general_outputs  <= `PVSR_RST_GPO;
			enc_4b5b_en      <= `PVSR_RST_ENC;
			scramble_disable <= `PVSR_RST_SCR_DIS;
		end else if (soft_reset_in) begin
			general_outputs  <= `PVSR_RST_GPO;
			enc_4b5b_en      <= `PVSR_RST_ENC;
			scramble_disable <= `PVSR_RST_SCR_DIS;
		end else if (wr_special) begin
			general_outputs  <= mgmt_wdata_in[`PVSR_SP_GPO_HI:`PVSR_SP_GPO_LO];
			enc_4b5b_en      <= mgmt_wdata_in[`PVSR_SP_ENC_BIT];
			scramble_disable <= mgmt_wdata_in[`PVSR_SP_SCR_BIT];
		end
	end

	// Outputs registered once more so they come straight from flops
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			general_outputs_out <= `PVSR_RST_GPO;
			enc_4b5b_en_out     <= `PVSR_RST_ENC;
			scramble_en_out     <= ~`PVSR_RST_SCR_DIS;
		end else begin
			general_outputs_out <= general_outputs;
			enc_4b5b_en_out     <= enc_4b5b_en;
			scramble_en_out     <= ~scramble_disable;
		end
	end

	// ==========================================
	// Interrupt mask
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			irq_mask <= `PVSR_RST_MASK;
		else if (soft_reset_in)
			irq_mask <= `PVSR_RST_MASK;
		else if (wr_mask)
			irq_mask <= mgmt_wdata_in[`PVSR_IRQ_HI:`PVSR_IRQ_LO];
	end

	// ==========================================
	// Interrupt source flags, one cell per source
	pvsr_flag_cell #(.FALL_ASSERT(1'b0), .EDGE_DEASSERT(1'b1)) u_flag7 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (line_energy_present_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[7]),
		.flag_out      (irq_flags[7])
	);
	pvsr_flag_cell #(.FALL_ASSERT(1'b0), .EDGE_DEASSERT(1'b1)) u_flag6 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (neg_complete_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[6]),
		.flag_out      (irq_flags[6])
	);
	pvsr_flag_cell #(.FALL_ASSERT(1'b0), .EDGE_DEASSERT(1'b1)) u_flag5 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (remote_fault_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[5]),
		.flag_out      (irq_flags[5])
	);
	// Link down asserts on the falling link and clears only on request
	pvsr_flag_cell #(.FALL_ASSERT(1'b1), .EDGE_DEASSERT(1'b0)) u_flag4 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (link_up_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[4]),
		.flag_out      (irq_flags[4])
	);
	pvsr_flag_cell #(.FALL_ASSERT(1'b0), .EDGE_DEASSERT(1'b1)) u_flag3 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (partner_ack_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[3]),
		.flag_out      (irq_flags[3])
	);
	pvsr_flag_cell #(.FALL_ASSERT(1'b0), .EDGE_DEASSERT(1'b1)) u_flag2 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (parallel_fault_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[2]),
		.flag_out      (irq_flags[2])
	);
	pvsr_flag_cell #(.FALL_ASSERT(1'b0), .EDGE_DEASSERT(1'b1)) u_flag1 (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.soft_reset_in (soft_reset_in),
		.src_in        (page_received_in),
		.alt_mode_in   (alt_irq_mode_in),
		.rd_clear_in   (rd_flags),
		.wr_one_in     (wr_flags & mgmt_wdata_in[1]),
		.flag_out      (irq_flags[1])
	);

	// Interrupt pin: low while any enabled flag is latched
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			interrupt_out_n <= 1'b1;
		else
			interrupt_out_n <= ~|(irq_flags & irq_mask);
	end

	// ==========================================
	// Read data; unmapped and test addresses return zero
	always_comb begin
		next_rdata = 16'h0000;
		if (mgmt_addr_in == `PVSR_OFS_SYMERR) begin
			next_rdata = symbol_error_count;
		end else if (mgmt_addr_in == `PVSR_OFS_XOVER) begin
			next_rdata[`PVSR_XO_AUTO_BIT] = crossover_auto_control;
			next_rdata[`PVSR_XO_PAIR_BIT] = manual_pair_select;
			next_rdata[`PVSR_XO_HB_BIT]   = heartbeat_test_disable;
			next_rdata[`PVSR_XO_POL_BIT]  = rx_polarity_reversed;
		end else if (mgmt_addr_in == `PVSR_OFS_FLAGS) begin
			next_rdata[`PVSR_IRQ_HI:`PVSR_IRQ_LO] = irq_flags;
		end else if (mgmt_addr_in == `PVSR_OFS_MASK) begin
			next_rdata[`PVSR_IRQ_HI:`PVSR_IRQ_LO] = irq_mask;
		end else if (mgmt_addr_in == `PVSR_OFS_SPECIAL) begin
			next_rdata[`PVSR_SP_DONE_BIT]             = negotiation_done;
			next_rdata[`PVSR_SP_GPO_HI:`PVSR_SP_GPO_LO] = general_outputs;
			next_rdata[`PVSR_SP_ENC_BIT]              = enc_4b5b_en;
			next_rdata[`PVSR_SP_SPD_HI:`PVSR_SP_SPD_LO] = resolved_speed_duplex;
			next_rdata[`PVSR_SP_SCR_BIT]              = scramble_disable;
		end
	end

	// Read data holds until the next read
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mgmt_rdata_out <= 16'h0000;
		else if (mgmt_rd_in)
			mgmt_rdata_out <= next_rdata;
	end

	// ==========================================
	// Checks
	cnt_inc_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		speed_100_in && symbol_error_in && !rx_in_packet_in && !soft_reset_in
		|=> symbol_error_count == CNT_W'($past(symbol_error_count) + 1))
		else $error("idle symbol error not counted");
	one_per_pkt_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		pkt_state == PVSR_PKT_DONE && rx_in_packet_in && !soft_reset_in |=> $stable(symbol_error_count))
		else $error("second count within one packet");
	cnt_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		symbol_error_count == 16'hFFFF && cnt_inc && !soft_reset_in |=> symbol_error_count == 16'h0000)
		else $error("counter did not wrap");
	cnt_10m_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!speed_100_in && !soft_reset_in |=> $stable(symbol_error_count))
		else $error("counter moved at 10 Mb/s");
	pair_sel_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		crossover_auto_control |=> pair_swap_out == $past(manual_pair_select))
		else $error("manual pair selection ignored");
	heartbeat_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		##1 heartbeat_test_en_out == !$past(heartbeat_test_disable))
		else $error("heartbeat enable wrong");
	irq_pin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		|(irq_flags & irq_mask) |=> !interrupt_out_n)
		else $error("enabled flag did not raise interrupt");
	coding_out_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		wr_special && !soft_reset_in |-> ##2 enc_4b5b_en_out == $past(mgmt_wdata_in[`PVSR_SP_ENC_BIT], 2))
		else $error("4B5B enable not applied");
	gpo_out_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		##1 general_outputs_out == $past(general_outputs))
		else $error("general outputs not driven from register");

endmodule // pvsr_regs

`default_nettype wire

// ---- tb/phy_vendor_status_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "pvsr_consts.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("Error at %0t: got %h exp %h", $time, g, e); end end

module phy_vendor_status_regs_tb;
	import pvsr_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic soft_reset_in = 1'b0;
	logic spd100 = 1'b0;
	logic in_pkt = 1'b0;
	logic sym_err = 1'b0;
	logic pair_in = 1'b0;
	logic pol_in = 1'b0;
	logic [2:0] spd = 3'h1;
	logic alt = 1'b0;
	logic [7:1] src = 7'h00;
	logic rd_s, wr_s, pair, auto_en, hb_en, enc, scr, int_n;
	logic [4:0] addr;
	logic [2:0] gpo;
	pvsr_word_t wdata, rdata;
	int errors = 0;
	int tests_run = 0;

	// 25 MHz clock
	always #20 ref_clk_in = ~ref_clk_in;

	pvsr_regs i_pvsr_regs (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .soft_reset_in(soft_reset_in),
		.mgmt_rd_in(rd_s), .mgmt_wr_in(wr_s), .mgmt_addr_in(addr), .mgmt_wdata_in(wdata),
		.mgmt_rdata_out(rdata), .speed_100_in(spd100), .rx_in_packet_in(in_pkt),
		.symbol_error_in(sym_err), .auto_pair_swap_in(pair_in), .rx_polarity_reversed_in(pol_in),
		.resolved_speed_duplex_in(spd), .alt_irq_mode_in(alt), .line_energy_present_in(src[7]),
		.neg_complete_in(src[6]), .remote_fault_in(src[5]), .link_up_in(~src[4]),
		.partner_ack_in(src[3]), .parallel_fault_in(src[2]), .page_received_in(src[1]),
		.pair_swap_out(pair), .auto_crossover_en_out(auto_en), .heartbeat_test_en_out(hb_en),
		.general_outputs_out(gpo), .enc_4b5b_en_out(enc), .scramble_en_out(scr), .interrupt_out_n(int_n));

	pvsr_mgmt_model i_pvsr_mgmt_model (.ref_clk_in(ref_clk_in), .mgmt_rdata_in(rdata), .mgmt_rd_out(rd_s),
		.mgmt_wr_out(wr_s), .mgmt_addr_out(addr), .mgmt_wdata_out(wdata));

	// ==========================================
	// Shared helpers
	task automatic rd(input logic [4:0] a, output pvsr_word_t d);
		i_pvsr_mgmt_model.rd(a, d);
	endtask
	task automatic wr(input logic [4:0] a, input pvsr_word_t d);
		i_pvsr_mgmt_model.wr(a, d);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	// Error line held high n cycles gives n invalid symbols
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk_in);
			sym_err <= 1'b1;
		end
		@(posedge ref_clk_in);
		sym_err <= 1'b0;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		pvsr_word_t d;
		settle(1);
		`CHK({auto_en, hb_en, enc, scr, pair, gpo, int_n}, 9'h1E1)
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0000)
		rd(`PVSR_OFS_MASK, d);
		`CHK(d, 16'h0000)
		rd(`PVSR_OFS_SPECIAL, d);
		`CHK(d, 16'h0044)
	endtask

	task automatic t_counter();
		pvsr_word_t d;
		@(posedge ref_clk_in);
		spd100 <= 1'b1;
		pulse(3);
		@(posedge ref_clk_in);
		in_pkt <= 1'b1;
		pulse(3);
		@(posedge ref_clk_in);
		in_pkt <= 1'b0;
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0004)
		@(posedge ref_clk_in);
		spd100 <= 1'b0;
		pulse(5);
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0004)
		@(posedge ref_clk_in);
		spd100 <= 1'b1;
		pulse(65532);
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0000)
		wr(`PVSR_OFS_SYMERR, 16'hFFFF); // Read-only target
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0000)
	endtask

	task automatic t_xover();
		pvsr_word_t d;
		@(posedge ref_clk_in);
		pair_in <= 1'b1;
		pol_in <= 1'b1;
		settle(3);
		`CHK(pair, 1'b1)
		wr(`PVSR_OFS_XOVER, 16'hA800);
		@(posedge ref_clk_in);
		pair_in <= 1'b0;
		settle(3);
		`CHK({auto_en, pair, hb_en}, 3'h2)
		rd(`PVSR_OFS_XOVER, d);
		`CHK(d, 16'hA810)
		wr(`PVSR_OFS_XOVER, 16'h8000);
		settle(2);
		`CHK({auto_en, pair, hb_en}, 3'h1)
		wr(`PVSR_OFS_XOVER, 16'h0000);
		settle(2);
		`CHK(auto_en, 1'b1)
	endtask

	task automatic t_flags();
		pvsr_word_t d;
		wr(`PVSR_OFS_MASK, 16'h00FE);
		rd(`PVSR_OFS_MASK, d);
		`CHK(d, 16'h00FE)
		for (int b = 1; b <= 7; b++) begin
			@(posedge ref_clk_in);
			src[b] <= 1'b1;
			settle(4);
			`CHK(int_n, 1'b0)
			rd(`PVSR_OFS_FLAGS, d);
			`CHK(d, 16'h0001 << b)
			settle(1);
			`CHK(int_n, 1'b1)
			@(posedge ref_clk_in);
			src[b] <= 1'b0;
			settle(3);
			rd(`PVSR_OFS_FLAGS, d);
			`CHK(d, 16'h0000)
		end
		wr(`PVSR_OFS_MASK, 16'h0000);
		@(posedge ref_clk_in);
		src[1] <= 1'b1;
		settle(4);
		`CHK(int_n, 1'b1)
		rd(`PVSR_OFS_FLAGS, d);
		`CHK(d, 16'h0002)
		@(posedge ref_clk_in);
		src[1] <= 1'b0;
	endtask

	task automatic t_alt();
		pvsr_word_t d;
		@(posedge ref_clk_in);
		alt <= 1'b1;
		wr(`PVSR_OFS_MASK, 16'h0020);
		@(posedge ref_clk_in);
		src[5] <= 1'b1;
		settle(4);
		wr(`PVSR_OFS_FLAGS, 16'h0020);
		settle(3);
		`CHK(int_n, 1'b0)
		@(posedge ref_clk_in);
		src[5] <= 1'b0;
		settle(3);
		rd(`PVSR_OFS_FLAGS, d);
		`CHK(d, 16'h0020)
		wr(`PVSR_OFS_FLAGS, 16'h0020);
		settle(3);
		`CHK(int_n, 1'b1)
		rd(`PVSR_OFS_FLAGS, d);
		`CHK(d, 16'h0000)
		@(posedge ref_clk_in);
		alt <= 1'b0;
	endtask

	// Soft reset must return fields, counter and flags to their reset values
	task automatic t_soft();
		pvsr_word_t d;
		wr(`PVSR_OFS_XOVER, 16'hA800);
		wr(`PVSR_OFS_MASK, 16'h0040);
		pulse(2);
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0002)
		`CHK(int_n, 1'b0)
		@(posedge ref_clk_in);
		soft_reset_in <= 1'b1;
		@(posedge ref_clk_in);
		soft_reset_in <= 1'b0;
		settle(3);
		`CHK({auto_en, hb_en, enc, scr, gpo, int_n}, 8'hF1)
		rd(`PVSR_OFS_SYMERR, d);
		`CHK(d, 16'h0000)
		rd(`PVSR_OFS_MASK, d);
		`CHK(d, 16'h0000)
		rd(`PVSR_OFS_FLAGS, d);
		`CHK(d, 16'h0000)
	endtask

	task automatic t_special();
		logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
		logic [2:0] g;
		pvsr_word_t d;
		for (int i = 0; i < 4; i++) begin
			g = 3'(2 * i + 1);
			@(posedge ref_clk_in);
			spd <= codes[i];
			src[6] <= i[0];
			wr(`PVSR_OFS_SPECIAL, {6'h00, g, i[0], 5'h00, i[1]});
			settle(2);
			`CHK({gpo, enc, scr}, {g, i[0], ~i[1]})
			rd(`PVSR_OFS_SPECIAL, d);
			`CHK(d, {3'h0, i[0], 2'h0, g, i[0], 1'b0, codes[i], 1'b0, i[1]})
		end
		rd(5'h05, d);
		`CHK(d, 16'h0000)
	endtask

	// ==========================================
	// Verdict
	task automatic finish_test();
		$display("Checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (99000) @(posedge ref_clk_in);
		errors++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_counter();
		t_xover();
		t_flags();
		t_alt();
		t_special();
		t_soft();
		finish_test();
	end
endmodule // phy_vendor_status_regs_tb

`default_nettype wire

// ---- tb/pvsr_mgmt_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Station management controller stand-in
module pvsr_mgmt_model (
	input  wire logic        ref_clk_in,
	input  wire logic [15:0] mgmt_rdata_in,
	output var  logic        mgmt_rd_out,
	output var  logic        mgmt_wr_out,
	output var  logic [4:0]  mgmt_addr_out,
	output var  logic [15:0] mgmt_wdata_out
);
	// Idle bus
	initial begin
		mgmt_rd_out = 1'b0;
		mgmt_wr_out = 1'b0;
		mgmt_addr_out = 5'h00;
		mgmt_wdata_out = 16'h0000;
	end

	// One-cycle write; a write to offset 5'h1C is never issued on the bus
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		if (a != 5'h1C) begin
			@(posedge ref_clk_in);
			mgmt_wr_out <= 1'b1;
			mgmt_addr_out <= a;
			mgmt_wdata_out <= d;
			@(posedge ref_clk_in);
			mgmt_wr_out <= 1'b0;
			mgmt_addr_out <= ~a; // Released lines show the inverse
			mgmt_wdata_out <= ~d;
		end
	endtask

	// Read; data is taken once the registered answer has landed
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk_in);
		mgmt_rd_out <= 1'b1;
		mgmt_addr_out <= a;
		@(posedge ref_clk_in);
		mgmt_rd_out <= 1'b0;
		mgmt_addr_out <= ~a;
		@(posedge ref_clk_in);
		#1 d = mgmt_rdata_in;
	endtask
endmodule // pvsr_mgmt_model

`default_nettype wire
